// ===== inc/efc_params.svh
// register offsets, field positions and timing counts of the front-end configuration bank
`ifndef EFC_PARAMS_SVH
`define EFC_PARAMS_SVH
`define EFC_ADDR_CONV 7'h00
`define EFC_ADDR_ROUTE1 7'h01
`define EFC_ADDR_ROUTE2 7'h02
`define EFC_ADDR_ROUTE3 7'h03
`define EFC_ADDR_CMDET 7'h0a
`define EFC_ADDR_LEGDRV 7'h0c
`define EFC_ADDR_WBUF1 7'h0d
`define EFC_ADDR_WBUF2 7'h0e
`define EFC_ADDR_WBUF3 7'h0f
`define EFC_ADDR_WOUT 7'h10
`define EFC_ADDR_CLKCFG 7'h12
`define EFC_ADDR_SHDN 7'h14
`define EFC_ADDR_DEC2 7'h21
`define EFC_ADDR_DEC3_1 7'h22
`define EFC_ADDR_DEC3_2 7'h23
`define EFC_ADDR_DEC3_3 7'h24
`define EFC_ADDR_RDYSRC 7'h27
`define EFC_ADDR_SYNCSRC 7'h28
`define EFC_ADDR_LOOPEN 7'h2f
`define EFC_ADDR_DATA_FIRST 7'h37
`define EFC_ADDR_DATA_LAST 7'h3f
`define EFC_ADDR_LOOP 7'h50
`define EFC_RESET_VAL 8'h00
`define EFC_CONV_START_BIT 0
`define EFC_CLK_OSC_BIT 2
`define EFC_CLK_OUT_BIT 0
`define EFC_CLK_EXT_VAL 8'h06
`define EFC_SRC_CH1_BIT 3
`define EFC_SYNC_IN_BIT 6
`define EFC_LOOP_CH1_BIT 4
`define EFC_SYNC_PULSE_CYC 4'h4
`endif

// ===== inc/efc_pkg.sv
// types of the front-end configuration bank
package efc_pkg;
	typedef enum logic [1:0]
	{
		EFC_IDLE = 2'b00,
		EFC_ADDR = 2'b01,
		EFC_DATA = 2'b10
	} efc_state_t;
	typedef logic [7:0] efc_byte_t;
endpackage : efc_pkg

// ===== verilog/efc_pin_sync.sv
// three-stage synchroniser for pins entering the sys_clk domain
module efc_pin_sync
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic pinIn,
	output logic pinLevel,
	output logic pinRise,
	output logic pinFall
);
	logic [2:0] stage;
	// stage[0] is only read by stage[1]; decisions use stages 1 and 2
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			stage <= 3'h0;
		else
			stage <= {stage[1:0], pinIn};
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			pinLevel <= 1'b0;
		else if (stage[1] == stage[2])
			pinLevel <= stage[2];
	end
	assign pinRise = (stage[1] == stage[2]) && stage[2] && !pinLevel;
	assign pinFall = (stage[1] == stage[2]) && !stage[2] && pinLevel;
endmodule : efc_pin_sync

// ===== verilog/efc_config_bank.sv
// configuration bank, serial register port and sample pacing of the front-end
// What this block does
// - writing 0x01 at 0x00 starts conversion; host repeats it per device
// - channel route registers hold positive and negative input pin selects
// - 0x07 at 0x0A enables common-mode detection on input pins 1 to 3
// - 0x04 at 0x0C routes leg drive amplifier to input pin 4
// - 0x01, 0x02, 0x03 at 0x0D-0x0F route Wilson buffers to pins 1-3
// - 0x01 at 0x10 routes Wilson terminal output to input pin 6
// - 0x04 at 0x12 selects crystal oscillator for the logic clock
// - 0x05 at 0x12 also enables the clock output driver
// - 0x06 at 0x12 takes the logic clock from the clock pin
// - 0x24 at 0x14 shuts down channel 3 signal path
// - 0x02 at 0x21 sets second decimation ratio 5 for all channels
// - 0x02 at 0x22-0x24 sets third decimation ratio 6 per channel
// - 0x08 at 0x27 makes channel 1 the sample ready source
// - 0x00 at 0x27 keeps the sample ready pin never asserted
// - 0x08 at 0x28 makes channel 1 the sync pulse source
// - 0x40 at 0x28 disables the sync driver, pin becomes input
// - master drives sync pulse to slave sync inputs for lockstep conversion
// - 0x2F selects channels in loop read-back: 0x70 all, 0x30 ch1-2
// - loop read-back address returns enabled data bytes 0x37-0x3F in turn, or 0x3D-0x3F when none is enabled
// - each 24-bit sample spans three bytes, upper byte at lowest address
`include "efc_params.svh"
module efc_config_bank
#(
	parameter int SAMPLE_DIV = 64
)
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic chip_select_n,
	input wire logic serialClk,
	input wire logic serialIn,
	output logic serialOut,
	output logic serialOutEn,
	input wire logic sample_sync_n_in,
	output logic sample_sync_n_out,
	output logic sample_sync_n_oe,
	output logic sample_ready_n,
	output logic clockOutEnable,
	output logic externalClockSel,
	output logic convRunning,
	input wire logic [23:0] ch1Sample,
	input wire logic [23:0] ch2Sample,
	input wire logic [23:0] ch3Sample,
	output efc_pkg::efc_byte_t analogCtl [0:18]
);
	import efc_pkg::*;

	logic csLevel;
	logic sckRise;
	logic sckFall;
	logic sdiLevel;
	logic syncLevel;
	logic syncFall;
	efc_pin_sync csSync (.sys_clk(sys_clk), .srst(srst), .pinIn(chip_select_n),
		.pinLevel(csLevel), .pinRise(), .pinFall());
	efc_pin_sync sckSync (.sys_clk(sys_clk), .srst(srst), .pinIn(serialClk),
		.pinLevel(), .pinRise(sckRise), .pinFall(sckFall));
	efc_pin_sync sdiSync (.sys_clk(sys_clk), .srst(srst), .pinIn(serialIn),
		.pinLevel(sdiLevel), .pinRise(), .pinFall());
	efc_pin_sync synSync (.sys_clk(sys_clk), .srst(srst), .pinIn(sample_sync_n_in),
		.pinLevel(syncLevel), .pinRise(), .pinFall(syncFall));

	// register storage; index matches the order of the address list
	localparam int NREG = 19;
	efc_byte_t regs [0:NREG-1];
	logic [6:0] regAddr [0:NREG-1];
	assign regAddr[0] = `EFC_ADDR_CONV;
	assign regAddr[1] = `EFC_ADDR_ROUTE1;
	assign regAddr[2] = `EFC_ADDR_ROUTE2;
	assign regAddr[3] = `EFC_ADDR_ROUTE3;
	assign regAddr[4] = `EFC_ADDR_CMDET;
	assign regAddr[5] = `EFC_ADDR_LEGDRV;
	assign regAddr[6] = `EFC_ADDR_WBUF1;
	assign regAddr[7] = `EFC_ADDR_WBUF2;
	assign regAddr[8] = `EFC_ADDR_WBUF3;
	assign regAddr[9] = `EFC_ADDR_WOUT;
	assign regAddr[10] = `EFC_ADDR_CLKCFG;
	assign regAddr[11] = `EFC_ADDR_SHDN;
	assign regAddr[12] = `EFC_ADDR_DEC2;
	assign regAddr[13] = `EFC_ADDR_DEC3_1;
	assign regAddr[14] = `EFC_ADDR_DEC3_2;
	assign regAddr[15] = `EFC_ADDR_DEC3_3;
	assign regAddr[16] = `EFC_ADDR_RDYSRC;
	assign regAddr[17] = `EFC_ADDR_SYNCSRC;
	assign regAddr[18] = `EFC_ADDR_LOOPEN;

	// serial frame: bit7 = read, bits 6..0 address, then one or more data bytes, msb first
	efc_state_t state;
	logic [2:0] bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] shiftOut;
	logic [6:0] curAddr;
	logic isRead;
	logic wrStrobe;
	logic rdLoad;
	logic [7:0] lastIn;
	assign lastIn = {shiftIn[6:0], sdiLevel};
	assign wrStrobe = (state == EFC_DATA) && sckRise && (bitCnt == 3'h7) && !isRead;
	assign rdLoad = (state == EFC_ADDR) && sckRise && (bitCnt == 3'h7) && lastIn[7];

	always_ff @(posedge sys_clk)
	begin
		if (srst || csLevel)
		begin
			state <= EFC_IDLE;
			bitCnt <= 3'h0;
			shiftIn <= 8'h00;
			curAddr <= 7'h00;
			isRead <= 1'b0;
		end
		else if (sckRise)
		begin
			shiftIn <= lastIn;
			bitCnt <= bitCnt + 3'h1;
			case (state)
				EFC_IDLE, EFC_ADDR:
				begin
					state <= EFC_ADDR;
					if (bitCnt == 3'h7)
					begin
						state <= EFC_DATA;
						isRead <= lastIn[7];
						curAddr <= lastIn[6:0];
					end
				end
				EFC_DATA:
				begin
					// streaming: stay in data phase, step address except at loop port
					if (bitCnt == 3'h7 && curAddr != `EFC_ADDR_LOOP)
						curAddr <= curAddr + 7'h1;
				end
				default:
					state <= EFC_IDLE;
			endcase
		end
	end

	// multiple slaves sharing select all latch the same write
	generate
		for (genvar i = 0; i < NREG; i++)
		begin : regGen
			always_ff @(posedge sys_clk)
			begin
				if (srst)
					regs[i] <= `EFC_RESET_VAL;
				else if (wrStrobe && curAddr == regAddr[i])
					regs[i] <= lastIn;
			end
			always_ff @(posedge sys_clk)
			begin
				if (srst)
					analogCtl[i] <= `EFC_RESET_VAL;
				else
					analogCtl[i] <= regs[i];
			end
		end
	endgenerate

	// sample data snapshot, byte index 0 = ch1 upper byte at the first data address
	logic [7:0] dataBytes [0:8];
	logic [23:0] chSnap [0:2];
	logic sampleTick;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			chSnap[0] <= 24'h000000;
			chSnap[1] <= 24'h000000;
			chSnap[2] <= 24'h000000;
		end
		else if (sampleTick)
		begin
			chSnap[0] <= ch1Sample;
			chSnap[1] <= ch2Sample;
			chSnap[2] <= ch3Sample;
		end
	end
	generate
		for (genvar c = 0; c < 3; c++)
		begin : byteGen
			assign dataBytes[3*c] = chSnap[c][23:16];
			assign dataBytes[3*c+1] = chSnap[c][15:8];
			assign dataBytes[3*c+2] = chSnap[c][7:0];
		end
	endgenerate

	// loop read-back walks enabled channels only, and channel 3 alone when no channel is enabled
	logic [1:0] loopCh;
	logic [1:0] loopByte;
	logic [2:0] loopMask;
	assign loopMask = regs[18][`EFC_LOOP_CH1_BIT +: 3];

	function automatic logic [1:0] nextCh(input logic [1:0] cur, input logic [2:0] mask);
		logic [1:0] r;
		r = cur;
		if (cur == 2'h0 && mask[1])
			r = 2'h1;
		else if (cur != 2'h2 && mask[2])
			r = 2'h2;
		else if (mask[0])
			r = 2'h0;
		else if (mask[1])
			r = 2'h1;
		return r;
	endfunction : nextCh

	function automatic logic [1:0] firstCh(input logic [2:0] mask);
		return mask[0] ? 2'h0 : (mask[1] ? 2'h1 : 2'h2);
	endfunction : firstCh

	logic [7:0] rdValue;
	logic [6:0] rdAddr;
	logic loopRead;
	// the loop port keeps its address while streaming, others step to the next byte
	assign rdAddr = (state != EFC_DATA) ? lastIn[6:0] :
		((curAddr == `EFC_ADDR_LOOP) ? curAddr : curAddr + 7'h1);
	assign loopRead = (rdAddr == `EFC_ADDR_LOOP);
	always_comb
	begin
		rdValue = 8'h00;
		if (loopRead)
		begin
			if (state == EFC_DATA)
				rdValue = (loopByte == 2'h2) ?
					dataBytes[7'(nextCh(loopCh, loopMask)) * 3] :
					dataBytes[loopCh * 3 + loopByte + 1];
			else
				rdValue = dataBytes[firstCh(loopMask) * 3];
		end
		else if (rdAddr >= `EFC_ADDR_DATA_FIRST && rdAddr <= `EFC_ADDR_DATA_LAST)
			rdValue = dataBytes[4'(rdAddr - `EFC_ADDR_DATA_FIRST)];
		else
		begin
			for (int k = 0; k < NREG; k++)
			begin
				if (rdAddr == regAddr[k])
					rdValue = regs[k];
			end
		end
	end

	logic rdNext;
	assign rdNext = (state == EFC_DATA) && isRead && sckRise && (bitCnt == 3'h7);
	always_ff @(posedge sys_clk)
	begin
		if (srst || csLevel)
		begin
			loopCh <= 2'h0;
			loopByte <= 2'h0;
		end
		else if (rdLoad && loopRead)
		begin
			loopCh <= firstCh(loopMask);
			loopByte <= 2'h0;
		end
		else if (rdNext && curAddr == `EFC_ADDR_LOOP)
		begin
			if (loopByte == 2'h2)
			begin
				loopByte <= 2'h0;
				loopCh <= nextCh(loopCh, loopMask);
			end
			else
				loopByte <= loopByte + 2'h1;
		end
	end

	// output shifts on the falling serial edge, so the host samples on rising
	always_ff @(posedge sys_clk)
	begin
		if (srst || csLevel)
			shiftOut <= 8'h00;
		else if (rdLoad || rdNext)
			shiftOut <= rdValue;
		// the fall right after a byte boundary presents the freshly loaded msb
		else if (sckFall && state == EFC_DATA && bitCnt != 3'h0)
			shiftOut <= {shiftOut[6:0], 1'b0};
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst || csLevel)
		begin
			serialOut <= 1'b0;
			serialOutEn <= 1'b0;
		end
		else
		begin
			serialOut <= shiftOut[7];
			serialOutEn <= (state == EFC_DATA) && isRead;
		end
	end

	// clock source decode
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			clockOutEnable <= 1'b0;
			externalClockSel <= 1'b0;
		end
		else
		begin
			clockOutEnable <= regs[10][`EFC_CLK_OSC_BIT] && regs[10][`EFC_CLK_OUT_BIT];
			externalClockSel <= (regs[10] == `EFC_CLK_EXT_VAL);
		end
	end

	// sample pacing: a slave restarts its divider on the master's sync pulse
	logic [15:0] paceCnt;
	logic syncIsInput;
	assign syncIsInput = regs[17][`EFC_SYNC_IN_BIT];
	assign sampleTick = convRunning && (paceCnt == 16'(SAMPLE_DIV - 1));
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			convRunning <= 1'b0;
		else
			convRunning <= regs[0][`EFC_CONV_START_BIT];
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst || !convRunning)
			paceCnt <= 16'h0000;
		else if (sampleTick || (syncIsInput && syncFall))
			paceCnt <= 16'h0000;
		else
			paceCnt <= paceCnt + 16'h0001;
	end

	logic [3:0] syncHold;
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			syncHold <= 4'h0;
		else if (sampleTick && regs[17][`EFC_SRC_CH1_BIT] && !syncIsInput)
			syncHold <= `EFC_SYNC_PULSE_CYC;
		else if (syncHold != 4'h0)
			syncHold <= syncHold - 4'h1;
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			sample_sync_n_out <= 1'b1;
			sample_sync_n_oe <= 1'b0;
		end
		else
		begin
			sample_sync_n_out <= (syncHold == 4'h0);
			sample_sync_n_oe <= !syncIsInput;
		end
	end

	// ready goes low on a new sample and rises when the host starts a frame
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			sample_ready_n <= 1'b1;
		else if (sampleTick && regs[16][`EFC_SRC_CH1_BIT])
			sample_ready_n <= 1'b0;
		else if (!csLevel)
			sample_ready_n <= 1'b1;
	end

	// checks
	start_conv_a: assert property (@(posedge sys_clk) disable iff (srst)
		wrStrobe && curAddr == `EFC_ADDR_CONV && lastIn == 8'h01 |-> ##2 convRunning)
		else $error("conversion did not start");
	ready_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
		!regs[16][`EFC_SRC_CH1_BIT] && $fell(sample_ready_n) |-> 1'b0)
		else $error("ready asserted without source");
	sync_input_a: assert property (@(posedge sys_clk) disable iff (srst)
		$past(syncIsInput) && $past(syncIsInput, 2) |-> !sample_sync_n_oe)
		else $error("sync driven while input");
	sync_pulse_a: assert property (@(posedge sys_clk) disable iff (srst)
		$rose(syncHold != 4'h0) |-> (syncHold != 4'h0) [*4] ##1 syncHold == 4'h0)
		else $error("sync pulse width wrong");
	clk_out_a: assert property (@(posedge sys_clk) disable iff (srst)
		regs[10] == 8'h05 ##1 regs[10] == 8'h05 |=> clockOutEnable)
		else $error("clock output not enabled");
	ext_clk_a: assert property (@(posedge sys_clk) disable iff (srst)
		regs[10] == 8'h04 ##1 regs[10] == 8'h04 |=> !externalClockSel && !clockOutEnable)
		else $error("crystal mode decode wrong");
	reg_write_a: assert property (@(posedge sys_clk) disable iff (srst)
		wrStrobe && curAddr == `EFC_ADDR_DEC2 |=> regs[12] == $past(lastIn))
		else $error("register write lost");
	reg_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
		!wrStrobe |=> $stable(regs[18]))
		else $error("register changed without write");
	ready_src_a: assert property (@(posedge sys_clk) disable iff (srst)
		sampleTick && regs[16][`EFC_SRC_CH1_BIT] |=> !sample_ready_n)
		else $error("ready not asserted on sample");
	write_cov: cover property (@(posedge sys_clk) wrStrobe);
	loop_cov: cover property (@(posedge sys_clk) rdNext && curAddr == `EFC_ADDR_LOOP);
	sync_cov: cover property (@(posedge sys_clk) syncIsInput && syncFall && convRunning);
	ready_cov: cover property (@(posedge sys_clk) $fell(sample_ready_n));
endmodule : efc_config_bank

// ===== dv/efc_host_model.sv
// serial host model driving the configuration bank ports
module efc_host_model
(
	input wire logic sysClk,
	input wire logic sdo,
	output logic sck,
	output logic sdi,
	output logic [1:0] csN
);
	timeunit 1ns;
	timeprecision 100ps;
	initial
	begin
		sck = 1'b0;
		sdi = 1'b0;
		csN = 2'b11;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sysClk);
	endtask : tick
	// several selects low at once program identical slaves together
	task automatic sel(input logic [1:0] m);
		tick(1);
		csN <= ~m;
		tick(8);
	endtask : sel
	task automatic desel();
		tick(4);
		csN <= 2'b11;
		// a released data line must not keep its last bit
		sdi <= ~sdi;
		tick(8);
	endtask : desel
	// msb first; clock idles low and stands still between frames
	task automatic bytex(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			sdi <= tx[i];
			tick(4);
			sck <= 1'b1;
			tick(4);
			rx[i] = sdo;
			sck <= 1'b0;
		end
	endtask : bytex
endmodule : efc_host_model

// ===== dv/test_ecg_frontend_config_sync.sv
// self-checking bench of the front-end configuration bank, master and slave
`include "efc_params.svh"
module test_ecg_frontend_config_sync;
	import efc_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic sysClk = 1'b0;
	logic srst = 1'b1;
	logic sck, sdi, sdo, outM, oeM, outS, oeS;
	logic [1:0] csN;
	logic syncOutM, syncOeM, syncOutS, syncOeS, syncWire;
	logic rdyM, rdyS, ckoM, ckoS, extM, extS, runM, runS;
	logic slaveRdy = 1'b0;
	logic [23:0] s1 = 24'h123456;
	logic [23:0] s2 = 24'h9abcde;
	logic [23:0] s3 = 24'h0f1e2d;
	efc_byte_t ctlM [0:18];
	efc_byte_t ctlS [0:18];
	int errTotal = 0;
	int nTests = 0;
	int cyc = 0;
	logic [6:0] regA [0:18] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h0a, 7'h0c, 7'h0d, 7'h0e,
		7'h0f, 7'h10, 7'h12, 7'h14, 7'h21, 7'h22, 7'h23, 7'h24, 7'h27, 7'h28, 7'h2f};
	logic [7:0] mVal [0:18] = '{8'h00, 8'h11, 8'h19, 8'h2e, 8'h07, 8'h04, 8'h01, 8'h02,
		8'h03, 8'h01, 8'h05, 8'h24, 8'h02, 8'h02, 8'h02, 8'h02, 8'h08, 8'h08, 8'h30};
	logic [7:0] sVal [0:18] = '{8'h00, 8'h0c, 8'h14, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h06, 8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h00, 8'h40, 8'h70};
	// data line floats when neither bank drives; the sync pin has a pull-up
	assign sdo = oeM ? outM : (oeS ? outS : 1'bz);
	assign syncWire = syncOeM ? syncOutM : (syncOeS ? syncOutS : 1'b1);
	initial
	begin
		forever #12.5 sysClk = ~sysClk;
	end
	efc_host_model hostU
	(
		.sysClk(sysClk), .sdo(sdo), .sck(sck), .sdi(sdi), .csN(csN)
	);
	efc_config_bank #(.SAMPLE_DIV(16)) dut_u
	(
		.sys_clk(sysClk), .srst(srst), .chip_select_n(csN[0]), .serialClk(sck),
		.serialIn(sdi), .serialOut(outM), .serialOutEn(oeM), .sample_sync_n_in(syncWire),
		.sample_sync_n_out(syncOutM), .sample_sync_n_oe(syncOeM), .sample_ready_n(rdyM),
		.clockOutEnable(ckoM), .externalClockSel(extM), .convRunning(runM),
		.ch1Sample(s1), .ch2Sample(s2), .ch3Sample(s3), .analogCtl(ctlM)
	);
	efc_config_bank #(.SAMPLE_DIV(16)) slaveU
	(
		.sys_clk(sysClk), .srst(srst), .chip_select_n(csN[1]), .serialClk(sck),
		.serialIn(sdi), .serialOut(outS), .serialOutEn(oeS), .sample_sync_n_in(syncWire),
		.sample_sync_n_out(syncOutS), .sample_sync_n_oe(syncOeS), .sample_ready_n(rdyS),
		.clockOutEnable(ckoS), .externalClockSel(extS), .convRunning(runS),
		.ch1Sample(s1), .ch2Sample(s2), .ch3Sample(s3), .analogCtl(ctlS)
	);
	task automatic wrapUp();
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrapUp
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		nTests++;
		if (got !== exp)
		begin
			errTotal++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [1:0] m, input logic [6:0] a, input logic [7:0] d);
		logic [7:0] rx;
		hostU.sel(m);
		hostU.bytex({1'b0, a}, rx);
		hostU.bytex(d, rx);
		hostU.desel();
	endtask : wr
	task automatic rd(input logic [1:0] m, input logic [6:0] a, output logic [7:0] d);
		logic [7:0] rx;
		hostU.sel(m);
		hostU.bytex({1'b1, a}, rx);
		hostU.bytex(8'h00, d);
		hostU.desel();
	endtask : rd
	// the timeout covers about a hundred frames of some 150 cycles each, with margin
	always @(posedge sysClk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			errTotal++;
			wrapUp();
		end
	end
	always @(negedge sysClk)
	begin
		if (runS === 1'b1 && rdyS !== 1'b1)
			slaveRdy <= 1'b1;
	end
	initial
	begin
		logic [7:0] d;
		logic [47:0] lb;
		int n;
		repeat (5) @(posedge sysClk);
		srst <= 1'b0;
		hostU.tick(8);
		for (int i = 0; i < 19; i++)
		begin
			rd(2'b01, regA[i], d);
			chk("reset value", 8'h00, d);
		end
		for (int i = 1; i < 19; i++)
			wr(2'b11, regA[i], sVal[i]);
		for (int i = 1; i < 19; i++)
			wr(2'b01, regA[i], mVal[i]);
		wr(2'b01, 7'h05, 8'h5a);
		rd(2'b01, 7'h05, d);
		chk("unmapped read", 8'h00, d);
		for (int i = 1; i < 19; i++)
		begin
			rd(2'b01, regA[i], d);
			chk("master reg", mVal[i], d);
			chk("master ctl", mVal[i], ctlM[i]);
			rd(2'b10, regA[i], d);
			chk("slave reg", sVal[i], d);
			chk("slave ctl", sVal[i], ctlS[i]);
		end
		chk("master clock out", 1'b1, ckoM);
		chk("master ext clock", 1'b0, extM);
		chk("slave ext clock", 1'b1, extS);
		chk("slave clock out", 1'b0, ckoS);
		chk("master sync drive", 1'b1, syncOeM);
		chk("slave sync drive", 1'b0, syncOeS);
		wr(2'b01, `EFC_ADDR_CLKCFG, 8'h04);
		chk("crystal clock out", 1'b0, ckoM);
		chk("crystal ext", 1'b0, extM);
		wr(2'b01, `EFC_ADDR_CONV, 8'h01);
		chk("master running", 1'b1, runM);
		chk("slave idle", 1'b0, runS);
		wr(2'b10, `EFC_ADDR_CONV, 8'h01);
		chk("slave running", 1'b1, runS);
		n = 0;
		@(negedge sysClk);
		while (syncWire !== 1'b0 && n < 100)
		begin
			@(negedge sysClk);
			n++;
		end
		n = 0;
		while (syncWire === 1'b0 && n < 20)
		begin
			@(negedge sysClk);
			n++;
		end
		chk("sync pulse length", 4, n);
		repeat (40) @(negedge sysClk);
		chk("master ready", 1'b0, rdyM);
		chk("slave ready kept high", 1'b0, slaveRdy);
		// channels 1 and 2 enabled: six bytes, upper byte first
		lb = {s1, s2};
		hostU.sel(2'b01);
		hostU.bytex({1'b1, `EFC_ADDR_LOOP}, d);
		for (int k = 0; k < 6; k++)
		begin
			hostU.bytex(8'h00, d);
			chk("loop byte", lb[47 - 8 * k -: 8], d);
		end
		hostU.desel();
		hostU.sel(2'b01);
		hostU.bytex({1'b1, `EFC_ADDR_DATA_FIRST}, d);
		for (int k = 0; k < 3; k++)
		begin
			hostU.bytex(8'h00, d);
			chk("sample byte", s1[23 - 8 * k -: 8], d);
		end
		hostU.desel();
		wrapUp();
	end
endmodule : test_ecg_frontend_config_sync
